// ===== core/pss_top.sv
// port scan and channel address sequencer with its register slave
`timescale 1ns/1ps
`include "pss_regs.svh"

module pss_top
    import pss_pkg::*;
(
    // clock, reset, clock enable
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    // bit clock tick from the overhead generator, one cycle wide
    input  wire logic        bit_clock,
    // current minor frame number from the overhead generator
    input  wire logic [4:0]  minor_frame,
    // outputs to the gated clock and overhead logic
    output pss_gc_t          gated_clock_logic,
    output pss_ovh_t         overhead_generator_logic,
    output logic             scan_end_preset_n,
    // axi4-lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    // axi4-lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // axi4-lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // axi4-lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    // axi4-lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp
);

    // --------------------------------------------------------------
    // declarations
    // --------------------------------------------------------------
    logic        run_q;
    logic [30:0] strap_q;
    logic [4:0]  piu_q;
    logic [4:0]  svc_q;
    logic [4:0]  ram_radr_q;
    logic [3:0]  ram_rdata;
    logic [4:0]  cnt_q,  cnt_d;
    logic [3:0]  chan_q, chan_d;
    logic [3:0]  max_q;
    logic        eos_q;
    logic        mf_q;
    logic        tick, scan_match, first_port, strap_bit, mf_hit;
    logic [4:0]  port_idx;
    pss_wr_st_t  ws_q;
    pss_rd_st_t  rs_q;
    logic        aw_hold_q, w_hold_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        aw_take, w_take, ar_take, wr_go, wr_ok, rd_ok;
    logic [31:0] status_word, rd_word;
    logic [31:0] strap_full, wr_mask;

    // --------------------------------------------------------------
    // scan decode
    // --------------------------------------------------------------
    // one scan step per bit clock tick while enabled
    assign tick       = ce && run_q && bit_clock;
    // >= rather than == so a count lowered mid-scan cannot run away
    assign scan_match = (cnt_q >= piu_q) || (cnt_q == `PSS_CNT_LAST);
    assign first_port = (cnt_q == `PSS_CNT_PRESET);
    assign port_idx   = cnt_q - `PSS_CNT_PRESET;
    // port one is hardwired as a new channel
    assign strap_full = {1'b0, strap_q[30:1], 1'b1};
    assign strap_bit  = strap_full[port_idx];
    assign scan_end_preset_n = !(tick && scan_match);

    // next scan count: ascending, preset to one after the last port
    assign cnt_d = scan_match ? `PSS_CNT_PRESET
                              : cnt_q + `PSS_CNT_PRESET;

    // channel counter restarts each scan and steps only on new channels
    assign chan_d = first_port ? `PSS_CHAN_FIRST
                  : (strap_bit && chan_q != `PSS_CHAN_LAST)
                  ? chan_q + `PSS_CHAN_FIRST : chan_q;

    // --------------------------------------------------------------
    // scan registers
    // --------------------------------------------------------------
    // counter, end-of-scan flag and channel address step together
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q  <= `PSS_CNT_PRESET;
            eos_q  <= 1'b0;
            chan_q <= 4'h0;
            max_q  <= 4'h0;
        end else if (tick) begin
            cnt_q  <= cnt_d;
            eos_q  <= scan_match;
            chan_q <= chan_d;
            if (scan_match) begin
                max_q <= chan_d;
            end
        end
    end

    // minor frame match for the selected service port
    assign mf_hit = run_q && (svc_q != 5'h00) && (svc_q <= piu_q)
                  && (minor_frame == svc_q);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mf_q <= 1'b0;
        end else if (ce) begin
            mf_q <= mf_hit;
        end
    end

    // outputs to the partner cards, all from flops except scan_end_preset_n
    assign gated_clock_logic.scan_end  = eos_q;
    assign gated_clock_logic.chan_addr = chan_q;
    assign gated_clock_logic.mf_match  = mf_q;
    assign overhead_generator_logic.scan_end = eos_q;

    // --------------------------------------------------------------
    // channel memory
    // --------------------------------------------------------------
    // one word per used port, addressed by port number minus one
    pss_chan_ram u_ram (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .ce      (ce),
        .we      (tick),
        .waddr   (port_idx),
        .wdata   (chan_d),
        .raddr   (ram_radr_q),
        .rdata   (ram_rdata)
    );

    // --------------------------------------------------------------
    // bus write path
    // --------------------------------------------------------------
    // address and data are taken independently, in either order
    assign s_axi_awready = ce && (ws_q == WS_COLLECT) && !aw_hold_q;
    assign s_axi_wready  = ce && (ws_q == WS_COLLECT) && !w_hold_q;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take  = s_axi_wvalid && s_axi_wready;
    assign wr_go   = ce && (ws_q == WS_COLLECT) && aw_hold_q && w_hold_q;
    assign wr_ok   = (aw_addr_q == `PSS_OFF_CTRL)
                  || (aw_addr_q == `PSS_OFF_STRAP)
                  || (aw_addr_q == `PSS_OFF_PIU)
                  || (aw_addr_q == `PSS_OFF_SVC)
                  || (aw_addr_q == `PSS_OFF_RAM_ADR);
    assign wr_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                      {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

    // capture of the two write channels
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end else if (ce) begin
            if (aw_take) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_hold_q <= 1'b0;
            end
            if (w_take) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    // response state: one write at a time
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ws_q        <= WS_COLLECT;
            s_axi_bresp <= `PSS_RESP_OKAY;
        end else if (ce) begin
            unique case (ws_q)
                WS_COLLECT: if (wr_go) begin
                    ws_q        <= WS_RESP;
                    s_axi_bresp <= wr_ok ? `PSS_RESP_OKAY
                                         : `PSS_RESP_SLVERR;
                end
                WS_RESP: if (s_axi_bready) begin
                    ws_q <= WS_COLLECT;
                end
            endcase
        end
    end
    // gated by ce so a frozen slave never sees a response handshake
    assign s_axi_bvalid = ce && (ws_q == WS_RESP);

    // software-written registers, byte lanes honoured
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            run_q      <= `PSS_RST_RUN;
            strap_q    <= `PSS_RST_STRAP;
            piu_q      <= `PSS_RST_PIU;
            svc_q      <= `PSS_RST_SVC;
            ram_radr_q <= 5'h00;
        end else if (wr_go) begin
            unique case (aw_addr_q)
                `PSS_OFF_CTRL: if (w_strb_q[0]) begin
                    run_q <= w_data_q[`PSS_CTRL_RUN];
                end
                `PSS_OFF_STRAP: begin
                    strap_q <= (strap_q & ~wr_mask[30:0])
                             | (w_data_q[30:0] & wr_mask[30:0]);
                end
                `PSS_OFF_PIU: if (w_strb_q[0]) begin
                    piu_q <= w_data_q[4:0];
                end
                `PSS_OFF_SVC: if (w_strb_q[0]) begin
                    svc_q <= w_data_q[4:0];
                end
                `PSS_OFF_RAM_ADR: if (w_strb_q[0]) begin
                    ram_radr_q <= w_data_q[4:0];
                end
                default: ;
            endcase
        end
    end

    // --------------------------------------------------------------
    // bus read path
    // --------------------------------------------------------------
    assign status_word = {14'h0000, mf_q, eos_q, max_q, chan_q,
                          3'h0, cnt_q};
    assign s_axi_arready = ce && (rs_q == RS_IDLE);
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign rd_ok   = wr_ok_rd(s_axi_araddr);
    assign rd_word = (s_axi_araddr == `PSS_OFF_CTRL)
                   ? {31'h0000_0000, run_q}
                   : (s_axi_araddr == `PSS_OFF_STRAP) ? strap_full
                   : (s_axi_araddr == `PSS_OFF_PIU) ? {27'h0, piu_q}
                   : (s_axi_araddr == `PSS_OFF_SVC) ? {27'h0, svc_q}
                   : (s_axi_araddr == `PSS_OFF_STATUS) ? status_word
                   : (s_axi_araddr == `PSS_OFF_RAM_ADR)
                   ? {27'h0, ram_radr_q}
                   : (s_axi_araddr == `PSS_OFF_RAM_DAT)
                   ? {28'h0, ram_rdata} : 32'h0000_0000;

    function automatic logic wr_ok_rd(input logic [7:0] a);
        return (a == `PSS_OFF_CTRL) || (a == `PSS_OFF_STRAP)
            || (a == `PSS_OFF_PIU) || (a == `PSS_OFF_SVC)
            || (a == `PSS_OFF_STATUS) || (a == `PSS_OFF_RAM_ADR)
            || (a == `PSS_OFF_RAM_DAT);
    endfunction

    // read data is latched at acceptance and held until taken
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rs_q        <= RS_IDLE;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PSS_RESP_OKAY;
        end else if (ce) begin
            unique case (rs_q)
                RS_IDLE: if (ar_take) begin
                    rs_q        <= RS_DATA;
                    s_axi_rdata <= rd_word;
                    s_axi_rresp <= rd_ok ? `PSS_RESP_OKAY
                                         : `PSS_RESP_SLVERR;
                end
                RS_DATA: if (s_axi_rready) begin
                    rs_q <= RS_IDLE;
                end
            endcase
        end
    end
    assign s_axi_rvalid = ce && (rs_q == RS_DATA);

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    // helper: ticks since the last preset, and count at scan start
    logic [5:0] len_q;
    logic [4:0] piu_start_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            len_q       <= 6'h01;
            piu_start_q <= `PSS_RST_PIU;
        end else if (tick) begin
            len_q       <= scan_match ? 6'h01 : len_q + 6'h01;
            piu_start_q <= scan_match ? piu_q : piu_start_q;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    scan_wrap_a: assert property (tick && scan_match |=>
        cnt_q == 5'h01) else $error("counter not preset to one");
    scan_step_a: assert property (tick && !scan_match |=>
        cnt_q == $past(cnt_q) + 5'h01) else $error("counter not stepped");
    scan_hold_a: assert property (!tick |=> $stable(cnt_q))
        else $error("counter moved without a bit clock");
    eos_set_a: assert property (tick |=>
        eos_q == $past(cnt_q >= piu_q || cnt_q == 5'h1F))
        else $error("end-of-scan flag wrong");
    scan_len_a: assert property (tick && scan_match
        && piu_start_q == piu_q && piu_q != 5'h00
        |-> len_q == {1'b0, piu_q}) else $error("scan length wrong");
    chan_first_a: assert property (tick && cnt_q == 5'h01 |=>
        chan_q == 4'h1) else $error("scan not started at channel one");
    chan_hold_a: assert property (tick && cnt_q != 5'h01
        && !strap_bit |=> $stable(chan_q))
        else $error("channel stepped on an added port");
    chan_step_a: assert property (tick && cnt_q != 5'h01
        && strap_bit && chan_q < 4'hF |=> chan_q == $past(chan_q) + 4'h1)
        else $error("channel not stepped on a new port");
    mf_out_a: assert property (ce && mf_hit |=>
        gated_clock_logic.mf_match) else $error("minor frame match lost");
    cnt_range_a: assert property (cnt_q != 5'h00)
        else $error("scan counter left its range");
    eos_both_a: assert property ((gated_clock_logic.scan_end
        == overhead_generator_logic.scan_end)
        && (!gated_clock_logic.scan_end || cnt_q == 5'h01))
        else $error("end-of-scan outputs wrong");

    wrap_c: cover property (tick && scan_match ##1 eos_q);
    mf_c:   cover property (mf_q);
    wr_c:   cover property (s_axi_bvalid && s_axi_bready);
    rd_c:   cover property (s_axi_rvalid && s_axi_rready);

endmodule

// ===== core/pss_regs.svh
// register map, field positions and fixed counts of the port scan sequencer
//
// Function
// - pulse end-of-scan at every word end to gated-clock and overhead logic.
// - drive current channel address to gated-clock logic.
// - raise minor-frame match during the frame serving the selected used port.
// - one assignment bit per port for 31 ports; one is new channel.
// - port one assignment bit always reads as one.
// - ports two onward may open up to fourteen further channels.
// - ports are interrogated in ascending order from port one.
// - a 5-bit ports-in-use count sets how many ports each scan reads.
// - each scan writes one 4-bit channel address per used port.
// - 5-bit scan counter advances once per bit clock, addressing ports.
// - counter increments until end-of-scan, then presets to one.
// - end-of-scan register sets when counter equals the ports-in-use count; the code sets it at or above that count.
// - each scan lasts bit period times number of used ports.
// - channel counter steps only on ports marking a new channel.
// - 32 by 4 channel memory written only under write enable.
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH

// register byte offsets
`define PSS_OFF_CTRL     8'h00
`define PSS_OFF_STRAP    8'h04
`define PSS_OFF_PIU      8'h08
`define PSS_OFF_SVC      8'h0C
`define PSS_OFF_STATUS   8'h10
`define PSS_OFF_RAM_ADR  8'h14
`define PSS_OFF_RAM_DAT  8'h18

// reset values
`define PSS_RST_RUN      1'h0
`define PSS_RST_STRAP    31'h0000_0001
`define PSS_RST_PIU      5'h0F
`define PSS_RST_SVC      5'h00

// field positions
`define PSS_CTRL_RUN     0
`define PSS_ST_CNT_LSB   0
`define PSS_ST_CHAN_LSB  8
`define PSS_ST_MAX_LSB   12
`define PSS_ST_EOS       16
`define PSS_ST_MF        17

// counts and codes
`define PSS_CNT_PRESET   5'h01
`define PSS_CNT_LAST     5'h1F
`define PSS_CHAN_FIRST   4'h1
`define PSS_CHAN_LAST    4'hF
`define PSS_RESP_OKAY    2'h0
`define PSS_RESP_SLVERR  2'h2

`endif

// ===== core/pss_pkg.sv
// types shared by the port scan sequencer files
package pss_pkg;

    // signals toward the gated clock logic
    typedef struct packed {
        logic       scan_end;
        logic [3:0] chan_addr;
        logic       mf_match;
    } pss_gc_t;

    // signals toward the overhead generator logic
    typedef struct packed {
        logic       scan_end;
    } pss_ovh_t;

    // bus slave states
    typedef enum logic [0:0] {WS_COLLECT, WS_RESP} pss_wr_st_t;
    typedef enum logic [0:0] {RS_IDLE, RS_DATA} pss_rd_st_t;

endpackage

// ===== core/pss_chan_ram.sv
// channel address memory, 32 words of 4 bits
`timescale 1ns/1ps
`include "pss_regs.svh"

module pss_chan_ram
    import pss_pkg::*;
(
    // clock, reset, clock enable
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       ce,
    // write side from the scan logic
    input  wire logic       we,
    input  wire logic [4:0] waddr,
    input  wire logic [3:0] wdata,
    // read side
    input  wire logic [4:0] raddr,
    output logic      [3:0] rdata
);
    logic [3:0] mem [0:31];

    // --------------------------------------------------------------
    // storage
    // --------------------------------------------------------------
    // no reset on the array: unused words hold stale data harmlessly
    always_ff @(posedge ref_clk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read keeps the data output off the array decode
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 4'h0;
        end else if (ce) begin
            rdata <= mem[raddr];
        end
    end

endmodule

// ===== testbench/pss_far_end.sv
// far-side model: bit clock ticks and minor frame number
`timescale 1ns/1ps

module pss_far_end (
    // clock, reset, clock enable
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic ce,
    // tick and frame toward the sequencer
    output logic       bit_clock = 1'b0,
    output logic [4:0] minor_frame = 5'h00
);

    // ------------------------------------------------------------
    // tick source
    // ------------------------------------------------------------
    // a tick stays up until an edge with ce high consumes it, so a
    // frozen sequencer never loses one; random gaps give slow and
    // every-other-cycle spacing. frame steps per tick, not per word, so
    // the service window comes round within a short run
    task automatic run_ticks(input int n);
        int gap;
        for (int i = 0; i < n; i++) begin
            gap = $urandom % 4;
            repeat (gap) @(posedge ref_clk);
            @(posedge ref_clk);
            bit_clock <= 1'b1;
            do @(posedge ref_clk); while (!ce);
            bit_clock   <= 1'b0;
            minor_frame <= minor_frame + 5'h01;
        end
    endtask

endmodule

// ===== testbench/tb_port_scan_sequencer.sv
// self-checking bench for the port scan sequencer
`timescale 1ns/1ps
`include "pss_regs.svh"

module tb_port_scan_sequencer
    import pss_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        ref_clk       = 1'b0;
    logic        nrst          = 1'b0;
    logic        ce            = 1'b1;
    logic        s_axi_awvalid = 1'b0;
    logic [7:0]  s_axi_awaddr  = 8'h00;
    logic        s_axi_wvalid  = 1'b0;
    logic [31:0] s_axi_wdata   = 32'h0;
    logic        s_axi_bready  = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic [7:0]  s_axi_araddr  = 8'h00;
    logic        s_axi_rready  = 1'b0;
    logic        s_axi_awready;
    logic        s_axi_wready;
    logic        s_axi_bvalid;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_arready;
    logic        s_axi_rvalid;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        bit_clock;
    logic [4:0]  minor_frame;
    logic        scan_end_preset_n;
    pss_gc_t     gated_clock_logic;
    pss_ovh_t    overhead_generator_logic;
    // bench state
    int          errors        = 0;
    int          tests_run     = 0;
    logic        ce_rnd        = 1'b0;
    logic        run_sh        = 1'b0;
    logic        mf_chk        = 1'b0;
    logic        exp_mf        = 1'b0;
    logic        pre_n;
    logic [4:0]  svc_sh        = 5'h00;
    logic [4:0]  piu_sh        = 5'h0F;
    logic [3:0]  exp_ch [1:31];
    logic [33:0] q_rd   [$];
    logic [1:0]  q_wr   [$];
    logic [6:0]  q_scan [$];

    // clock at 25 MHz
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // design and far side
    // ------------------------------------------------------------
    pss_top i_pss_top (.ref_clk(ref_clk), .nrst(nrst), .ce(ce),
        .bit_clock(bit_clock), .minor_frame(minor_frame),
        .gated_clock_logic(gated_clock_logic),
        .overhead_generator_logic(overhead_generator_logic),
        .scan_end_preset_n(scan_end_preset_n),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp));

    pss_far_end i_pss_far_end (.ref_clk(ref_clk), .nrst(nrst), .ce(ce),
        .bit_clock(bit_clock), .minor_frame(minor_frame));

    // ------------------------------------------------------------
    // compare tasks and verdict
    // ------------------------------------------------------------
    task automatic report(input logic [33:0] e, input logic [33:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
        report(e, g);
    endtask
    task automatic cmp_wr(input logic [1:0] e, input logic [1:0] g);
        report({32'h0, e}, {32'h0, g});
    endtask
    task automatic cmp_scan(input logic [6:0] e, input logic [6:0] g);
        report({27'h0, e}, {27'h0, g});
    endtask
    task automatic cmp_mf(input logic e, input logic g);
        report({33'h0, e}, {33'h0, g});
    endtask

    task automatic stop_test();
        if (errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // bus master tasks; each notes its expected answer first
    // ------------------------------------------------------------
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        q_wr.push_back(r);
        @(posedge ref_clk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wvalid  <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_bready  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge ref_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] r);
        q_rd.push_back({r, d});
        @(posedge ref_clk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= a;
        s_axi_rready  <= 1'b1;
        do @(posedge ref_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge ref_clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // watchers: oldest note against each result as it appears
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (nrst && s_axi_rvalid && s_axi_rready)
            cmp_rd(q_rd.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (nrst && s_axi_bvalid && s_axi_bready)
            cmp_wr(q_wr.pop_front(), s_axi_bresp);
    end

    // preset strobe is combinational, so take it before the edge lands
    always @(posedge ref_clk) begin
        if (nrst && ce && bit_clock && run_sh) begin
            pre_n = scan_end_preset_n;
            #1;
            cmp_scan(q_scan.pop_front(), {gated_clock_logic.chan_addr,
                gated_clock_logic.scan_end, pre_n,
                overhead_generator_logic.scan_end});
        end
    end

    // service match follows the frame number one enabled edge later
    always @(posedge ref_clk) begin
        if (ce)
            exp_mf <= svc_sh != 5'h00 && svc_sh <= piu_sh
                      && minor_frame == svc_sh;
        if (mf_chk) begin
            #1;
            cmp_mf(exp_mf, gated_clock_logic.mf_match);
        end
    end

    // clock enable dropped at random to show frozen cycles
    always @(posedge ref_clk) ce <= !ce_rnd || ($urandom % 5 != 0);

    // watchdog, far beyond the expected few thousand cycles
    initial begin
        repeat (60000) @(posedge ref_clk);
        errors++;
        stop_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int          n;
        logic [30:0] strap;
        logic [3:0]  ch;
        void'($urandom(32'hF187));
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        axi_rd(`PSS_OFF_CTRL, 32'h0, `PSS_RESP_OKAY);
        axi_rd(`PSS_OFF_STRAP, 32'h1, `PSS_RESP_OKAY);
        axi_rd(`PSS_OFF_PIU, 32'hF, `PSS_RESP_OKAY);
        axi_rd(`PSS_OFF_SVC, 32'h0, `PSS_RESP_OKAY);
        axi_rd(8'h1C, 32'h0, `PSS_RESP_SLVERR);
        axi_wr(`PSS_OFF_STATUS, 32'hF, `PSS_RESP_SLVERR);
        axi_wr(`PSS_OFF_STRAP, 32'h0, `PSS_RESP_OKAY);
        axi_rd(`PSS_OFF_STRAP, 32'h1, `PSS_RESP_OKAY);
        ce_rnd = 1'b1;
        // full width with saturation, fifteen ports, then random from 15 to 31
        for (int c = 0; c < 3; c++) begin
            n = (c == 0) ? 31 : (c == 1) ? 15 : 15 + $urandom % 17;
            strap = (c == 0) ? 31'h7FFF_FFFE : 31'($urandom);
            ch = 4'h0;
            for (int k = 1; k <= n; k++) begin
                if (k == 1)
                    ch = 4'h1;
                else if (strap[k-1] && ch != 4'hF)
                    ch = ch + 4'h1;
                exp_ch[k] = ch;
            end
            piu_sh = 5'(n);
            svc_sh = 5'(1 + $urandom % n);
            axi_wr(`PSS_OFF_STRAP, {1'b0, strap}, `PSS_RESP_OKAY);
            axi_wr(`PSS_OFF_PIU, {27'h0, piu_sh}, `PSS_RESP_OKAY);
            axi_wr(`PSS_OFF_SVC, {27'h0, svc_sh}, `PSS_RESP_OKAY);
            axi_wr(`PSS_OFF_CTRL, 32'h1, `PSS_RESP_OKAY);
            run_sh = 1'b1;
            @(posedge ref_clk);
            mf_chk = 1'b1;
            // two words: the second shows preset to one and fresh channels
            for (int s = 0; s < 2; s++)
                for (int k = 1; k <= n; k++)
                    q_scan.push_back({exp_ch[k], k == n, k != n, k == n});
            i_pss_far_end.run_ticks(2 * n);
            @(posedge ref_clk);
            mf_chk = 1'b0;
            axi_wr(`PSS_OFF_CTRL, 32'h0, `PSS_RESP_OKAY);
            run_sh = 1'b0;
            axi_rd(`PSS_OFF_STATUS, {14'h0, 2'b01, exp_ch[n], exp_ch[n],
                   8'h01}, `PSS_RESP_OKAY);
            for (int k = 1; k <= n; k++) begin
                axi_wr(`PSS_OFF_RAM_ADR, 32'(k - 1), `PSS_RESP_OKAY);
                axi_rd(`PSS_OFF_RAM_DAT, {28'h0, exp_ch[k]},
                       `PSS_RESP_OKAY);
            end
        end
        repeat (4) @(posedge ref_clk);
        cmp_mf(1'b1, q_scan.size() == 0 && q_rd.size() == 0);
        stop_test();
    end

endmodule
